// File: verilog/adc_sample_sequencer_control.sv
/*
  Digital control of a sequence-based converter: four sample sequencers,
  result queues, trigger selection, priority arbitration, interrupt
  flags, the shared averager, loopback test and the converter clock.
  Assumes an APB master on clk_i, a converter core whose done and data
  come from logic on clk_i, and peripheral triggers from other domains.
*/
// Decided for this implementation: the address map and the APB slave port.
// Notes on behaviour
// - Four sequencers; capacity and queue depth 8, 4, 4 and 1.
// - Queue words are 32 bits, result in bits 9 to 0.
// - Each step has a 4-bit input nibble and a 4-bit control nibble.
// - A sequencer runs only while enabled; configuration stays writable.
// - A step with its interrupt bit set raises the raw flag.
// - A sequence ends after the step whose last bit is set.
// - Each queue is circular; reading its port pops the oldest entry.
// - Queue status shows head, tail, full and empty.
// - Per sequencer overrun and underrun flags are readable; the overrun flag is never set.
// - Converter clock divided from the system clock towards 16.667 MHz.
// - Raw flags read unmasked; output is raw AND mask.
// - Writing one clears a sequencer's interrupt; zero leaves it.
// - Concurrent triggers served by 2-bit rank, zero highest.
// - After reset sequencer 0 ranks highest, sequencer 3 lowest.
// - Each sequencer picks processor, always or a peripheral trigger.
// - A write of one to the kick register starts processor sequencers.
// - The averager folds up to 64 conversions into one entry.
// - Averager bypassed after reset; one setting shared by all.
// - Loopback mode exercises sequencing without analog input.
`timescale 1ns/1ps
`include "adc_seq_map.svh"
module adc_sample_sequencer_control (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire adc_seq_pkg::apb_req_t apb_req_i,
  output logic [31:0]                prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output adc_seq_pkg::conv_req_t     conv_req_o,
  input  wire adc_seq_pkg::conv_rsp_t conv_rsp_i,
  input  wire logic [3:0]            periph_trig_i,
  output logic                       adc_clk_o,
  output logic [3:0]                 irq_o
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  adc_seq_pkg::main_state_t s_q;
  adc_seq_pkg::main_state_t s_d;

  logic [3:0][9:0] q_head;
  logic [3:0][3:0] q_wr;
  logic [3:0][3:0] q_rd;
  logic [3:0]      q_full;
  logic [3:0]      q_empty;
  logic [3:0]      q_push;
  logic [3:0]      q_pop;
  logic [9:0]      sample;
  logic            sample_done;
  logic            avg_clear;
  logic            avg_feed;
  logic            avg_valid;
  logic [9:0]      avg_data;

  // --------------------------------------------------------------------
  // Result queues, one per sequencer
  // --------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : gen_queue
    result_queue #(
      .DEPTH (int'(adc_seq_pkg::seq_cap(2'(g))))
    ) u_queue (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .push_i      (q_push[g]),
      .push_data_i (avg_data),
      .pop_i       (q_pop[g]),
      .head_data_o (q_head[g]),
      .wr_ptr_o    (q_wr[g]),
      .rd_ptr_o    (q_rd[g]),
      .full_o      (q_full[g]),
      .empty_o     (q_empty[g]),
      .overrun_o   (),
      .underrun_o  ()
    );
  end

  // --------------------------------------------------------------------
  // Shared averager
  // --------------------------------------------------------------------
  sample_averager u_avg (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .clear_i     (avg_clear),
    .in_valid_i  (avg_feed),
    .in_data_i   (sample),
    .log2n_i     (s_q.avg_log2),
    .out_valid_o (avg_valid),
    .out_data_o  (avg_data)
  );

  // Loopback replaces the converter by a tagged pattern after a delay.
  assign sample      = s_q.loopback ?
                       {s_q.cur, s_q.step, s_q.conv_sel, 1'b0} :
                       conv_rsp_i.data;
  assign sample_done = s_q.loopback ? (s_q.lb_cnt == 4'h1) :
                       conv_rsp_i.done;
  assign avg_feed    = (s_q.fsm == adc_seq_pkg::SEQ_WAIT) && sample_done;
  assign avg_clear   = (s_q.fsm == adc_seq_pkg::SEQ_IDLE);

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic        access;
    logic        commit;
    logic [11:0] addr;
    logic [11:0] seq_ofs;
    logic        in_seq;
    logic [1:0]  sn;
    logic [4:0]  sub;
    logic [31:0] wd;
    logic [31:0] rd;
    logic        hit;
    logic [3:0]  edges;
    logic [3:0]  kick;
    logic [3:0]  fire;
    logic [3:0]  code;
    logic [3:0]  ready_seq;
    logic        found;
    logic [1:0]  best;
    logic [1:0]  best_rank;
    logic [3:0]  nib_ctl;
    logic        tick;
    s_d       = s_q;
    access    = apb_req_i.psel && apb_req_i.penable;
    commit    = access && s_q.ready;
    addr      = apb_req_i.paddr;
    seq_ofs   = addr - `OFS_SEQ_BASE;
    in_seq    = (addr >= `OFS_SEQ_BASE) && (addr < `OFS_SEQ_END) &&
                !seq_ofs[4];
    sn        = seq_ofs[6:5];
    sub       = seq_ofs[4:0];
    wd        = apb_req_i.pwdata;
    rd        = 32'h00000000;
    hit       = 1'b1;
    kick      = 4'h0;
    fire      = 4'h0;
    found     = 1'b0;
    best      = 2'h0;
    best_rank = 2'h3;
    q_push    = 4'h0;
    q_pop     = 4'h0;
    nib_ctl   = s_q.step_ctl[s_q.cur][{s_q.step, 2'h0} +: 4];
    code      = 4'h0;
    ready_seq = 4'h0;

    // Converter clock divider and peripheral trigger synchronisers.
    tick      = (s_q.div_cnt == 4'(`ADC_DIV - 1));
    s_d.div_cnt = tick ? 4'h0 : s_q.div_cnt + 4'h1;
    if (tick || (s_q.div_cnt == 4'(`ADC_HALF - 1))) begin
      s_d.adc_clk = !s_q.adc_clk;
    end
    s_d.trig_s1 = periph_trig_i;
    s_d.trig_s2 = s_q.trig_s1;
    s_d.trig_s3 = s_q.trig_s2;
    edges       = s_q.trig_s2 & ~s_q.trig_s3;

    // Bus read decode, sampled in the first access cycle.
    if (in_seq) begin
      case (sub)
        `SUB_INPUT_SEL:  rd = s_q.input_sel[sn];
        `SUB_STEP_CTL:   rd = s_q.step_ctl[sn];
        `SUB_QUEUE_PORT: rd = {22'h000000, q_head[sn]};
        `SUB_QUEUE_STAT: rd = {19'h00000, q_full[sn], 3'h0, q_empty[sn],
                               q_wr[sn], q_rd[sn]};
        default:         hit = 1'b0;
      endcase
    end else begin
      case (addr)
        `OFS_ACTIVATION:  rd = {28'h0000000, s_q.active};
        `OFS_RAW_IRQ:     rd = {28'h0000000, s_q.raw_irq};
        `OFS_IRQ_GATE:    rd = {28'h0000000, s_q.irq_gate};
        `OFS_IRQ_CLEAR:   rd = {28'h0000000, s_q.raw_irq & s_q.irq_gate};
        `OFS_OVERRUN:     rd = {28'h0000000, s_q.overrun};
        `OFS_TRIG_SOURCE: rd = {16'h0000, s_q.trig_src};
        `OFS_UNDERRUN:    rd = {28'h0000000, s_q.underrun};
        `OFS_RANK:        rd = {16'h0000, s_q.rank};
        `OFS_SW_KICK:     rd = 32'h00000000;
        `OFS_AVERAGER:    rd = {29'h00000000, s_q.avg_log2};
        `OFS_LOOPBACK:    rd = {31'h00000000, s_q.loopback};
        default:          hit = 1'b0;
      endcase
    end

    // One wait state: data, error and ready are registered at the same edge.
    s_d.ready = access && !s_q.ready;
    if (access && !s_q.ready) begin
      s_d.rdata  = rd;
      s_d.slverr = !hit;
    end

    // Bus writes and queue pops take effect at the completing edge.
    if (commit && !apb_req_i.pwrite && in_seq &&
        (sub == `SUB_QUEUE_PORT)) begin
      q_pop[sn] = 1'b1;
    end
    if (commit && apb_req_i.pwrite) begin
      if (in_seq && (sub == `SUB_INPUT_SEL)) begin
        s_d.input_sel[sn] = wd & adc_seq_pkg::nib_mask(sn);
      end
      if (in_seq && (sub == `SUB_STEP_CTL)) begin
        s_d.step_ctl[sn] = wd & adc_seq_pkg::nib_mask(sn);
      end
      case (addr)
        `OFS_ACTIVATION:  s_d.active   = wd[3:0];
        `OFS_IRQ_GATE:    s_d.irq_gate = wd[3:0];
        `OFS_IRQ_CLEAR:   s_d.raw_irq  = s_q.raw_irq & ~wd[3:0];
        `OFS_OVERRUN:     s_d.overrun  = s_q.overrun & ~wd[3:0];
        `OFS_UNDERRUN:    s_d.underrun = s_q.underrun & ~wd[3:0];
        `OFS_TRIG_SOURCE: s_d.trig_src = wd[15:0];
        `OFS_RANK:        s_d.rank     = wd[15:0] & `RANK_MASK;
        `OFS_SW_KICK:     kick         = wd[3:0];
        `OFS_AVERAGER:    s_d.avg_log2 = wd[2:0];
        `OFS_LOOPBACK:    s_d.loopback = wd[0];
        default:          ;
      endcase
    end

    // Queue fault flags are sticky; a new underrun wins over a clear, and no overrun is ever set.
    // Faults come from the registered full and empty flags, so the pop strobe made above
    // never loops back through the queues; q_push is only set further down, so the overrun term sees it at zero.
    s_d.overrun  = s_d.overrun | (q_push & q_full);
    s_d.underrun = s_d.underrun | (q_pop & q_empty);

    // Trigger selection per sequencer.
    for (int n = 0; n < 4; n++) begin
      code = s_q.trig_src[4*n +: 4];
      if (code == `TRIG_ALWAYS) begin
        fire[n] = 1'b1;
      end else if (code == `TRIG_PROCESSOR) begin
        fire[n] = kick[n];
      end else if ((code >= `TRIG_PERIPH_LO) &&
                   (code <= `TRIG_PERIPH_HI)) begin
        fire[n] = edges[2'(code - `TRIG_PERIPH_LO)];
      end
    end
    ready_seq = s_q.pending & s_q.active;

    // Lowest rank value among waiting sequencers wins.
    for (int n = 0; n < 4; n++) begin
      if (ready_seq[n] &&
          (!found || (s_q.rank[4*n +: 2] < best_rank))) begin
        found     = 1'b1;
        best      = 2'(n);
        best_rank = s_q.rank[4*n +: 2];
      end
    end

    // Sequencing engine.
    s_d.conv_start = 1'b0;
    case (s_q.fsm)
      adc_seq_pkg::SEQ_IDLE: begin
        if (found) begin
          s_d.cur          = best;
          s_d.step         = 3'h0;
          s_d.pending[best] = 1'b0;
          s_d.fsm          = adc_seq_pkg::SEQ_START;
        end
      end
      adc_seq_pkg::SEQ_START: begin
        if (!s_q.active[s_q.cur]) begin
          s_d.fsm = adc_seq_pkg::SEQ_IDLE;
        end else if (tick) begin
          s_d.conv_sel   = s_q.input_sel[s_q.cur][{s_q.step, 2'h0} +: 4];
          s_d.conv_ctl   = nib_ctl;
          s_d.conv_start = !s_q.loopback;
          s_d.lb_cnt     = `LOOPBACK_CYCLES;
          s_d.fsm        = adc_seq_pkg::SEQ_WAIT;
        end
      end
      adc_seq_pkg::SEQ_WAIT: begin
        if (s_q.lb_cnt != 4'h0) begin
          s_d.lb_cnt = s_q.lb_cnt - 4'h1;
        end
        if (!s_q.active[s_q.cur]) begin
          s_d.fsm = adc_seq_pkg::SEQ_IDLE;
        end else if (sample_done) begin
          s_d.fsm = adc_seq_pkg::SEQ_CHECK;
        end
      end
      adc_seq_pkg::SEQ_CHECK: begin
        if (avg_valid) begin
          q_push[s_q.cur] = 1'b1;
          if (nib_ctl[`CTL_IRQ]) begin
            s_d.raw_irq[s_q.cur] = 1'b1;
          end
          if (nib_ctl[`CTL_LAST] ||
              ({1'b0, s_q.step} == adc_seq_pkg::seq_cap(s_q.cur) - 4'h1))
          begin
            s_d.fsm = adc_seq_pkg::SEQ_IDLE;
          end else begin
            s_d.step = s_q.step + 3'h1;
            s_d.fsm  = adc_seq_pkg::SEQ_START;
          end
        end else begin
          s_d.fsm = adc_seq_pkg::SEQ_START;
        end
      end
      default: s_d.fsm = adc_seq_pkg::SEQ_IDLE;
    endcase

    // New triggers are latched last so they win over the start clear.
    s_d.pending = (s_d.pending | fire) & s_q.active;
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q             <= '0;
      s_q.rank        <= `RST_RANK;
      s_q.step_ctl[3] <= `RST_CTL3;
      s_q.fsm         <= adc_seq_pkg::SEQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata_o   = s_q.rdata;
  assign pready_o   = s_q.ready;
  assign pslverr_o  = s_q.ready && s_q.slverr;
  assign adc_clk_o  = s_q.adc_clk;
  assign irq_o      = s_q.raw_irq & s_q.irq_gate;
  assign conv_req_o = '{start:     s_q.conv_start,
                        input_sel: s_q.conv_sel,
                        step_ctl:  s_q.conv_ctl};

endmodule

// File: verilog/adc_seq_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  sample sequencer control block.
  Assumes byte addresses on a 32-bit APB, one aligned word per register.
*/
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_ACTIVATION   12'h000
`define OFS_RAW_IRQ      12'h004
`define OFS_IRQ_GATE     12'h008
`define OFS_IRQ_CLEAR    12'h00C
`define OFS_OVERRUN      12'h010
`define OFS_TRIG_SOURCE  12'h014
`define OFS_UNDERRUN     12'h018
`define OFS_RANK         12'h020
`define OFS_SW_KICK      12'h028
`define OFS_AVERAGER     12'h030
`define OFS_SEQ_BASE     12'h040
`define OFS_SEQ_END      12'h0C0
`define OFS_LOOPBACK     12'h100
`define SUB_INPUT_SEL    5'h00
`define SUB_STEP_CTL     5'h04
`define SUB_QUEUE_PORT   5'h08
`define SUB_QUEUE_STAT   5'h0C

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_RANK         16'h3210
`define RST_CTL3         32'h00000002

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL_DIFF         0
`define CTL_LAST         1
`define CTL_IRQ          2
`define CTL_TEMP         3
`define STAT_EMPTY       8
`define STAT_FULL        12
`define RANK_MASK        16'h3333

// ----------------------------------------------------------------------
// Trigger source codes
// ----------------------------------------------------------------------
`define TRIG_PROCESSOR   4'h0
`define TRIG_PERIPH_LO   4'h1
`define TRIG_PERIPH_HI   4'h4
`define TRIG_ALWAYS      4'hF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_KHZ          200000
`define ADC_TARGET_KHZ   16667
`define ADC_DIV          ((`CLK_KHZ + `ADC_TARGET_KHZ / 2) / `ADC_TARGET_KHZ)
`define ADC_HALF         (`ADC_DIV / 2)
`define LOOPBACK_CYCLES  4'h4
`define MAX_AVG_LOG2     3'h6

`endif

// File: verilog/adc_seq_pkg.sv
/*
  Types shared by the sample sequencer control block: bus and converter
  carriers, the sequencing state enumeration and the main state record.
  Assumes adc_seq_map.svh for the numbers.
*/
package adc_seq_pkg;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic       start;
    logic [3:0] input_sel;
    logic [3:0] step_ctl;
  } conv_req_t;

  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } conv_rsp_t;

  // --------------------------------------------------------------------
  // Sequencing state
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_START,
    SEQ_WAIT,
    SEQ_CHECK
  } seq_state_t;

  typedef struct packed {
    logic [3:0]        active;
    logic [3:0]        raw_irq;
    logic [3:0]        irq_gate;
    logic [3:0]        overrun;
    logic [3:0]        underrun;
    logic [15:0]       trig_src;
    logic [15:0]       rank;
    logic [2:0]        avg_log2;
    logic              loopback;
    logic [3:0][31:0]  input_sel;
    logic [3:0][31:0]  step_ctl;
    logic [3:0]        pending;
    seq_state_t        fsm;
    logic [1:0]        cur;
    logic [2:0]        step;
    logic [3:0]        div_cnt;
    logic              adc_clk;
    logic [3:0]        lb_cnt;
    logic              ready;
    logic              slverr;
    logic [31:0]       rdata;
    logic              conv_start;
    logic [3:0]        conv_sel;
    logic [3:0]        conv_ctl;
    logic [3:0]        trig_s1;
    logic [3:0]        trig_s2;
    logic [3:0]        trig_s3;
  } main_state_t;

  // Step capacity and result queue depth of each sequencer.
  function automatic logic [3:0] seq_cap(input logic [1:0] n);
    case (n)
      2'h0:    seq_cap = 4'h8;
      2'h3:    seq_cap = 4'h1;
      default: seq_cap = 4'h4;
    endcase
  endfunction

  // Bits of the step registers that exist for a sequencer.
  function automatic logic [31:0] nib_mask(input logic [1:0] n);
    case (n)
      2'h0:    nib_mask = 32'hFFFFFFFF;
      2'h3:    nib_mask = 32'h0000000F;
      default: nib_mask = 32'h0000FFFF;
    endcase
  endfunction

endpackage

// File: verilog/result_queue.sv
/*
  Circular result queue of one sequencer, DEPTH entries of ten bits.
  The oldest entry is kept prefetched in a register so that a bus read can
  return it; pushes into a full queue and pops from an empty one are
  reported and do not move the pointers.
*/
`timescale 1ns/1ps
module result_queue #(
  parameter int DEPTH = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       push_i,
  input  wire logic [9:0] push_data_i,
  input  wire logic       pop_i,
  output logic [9:0]      head_data_o,
  output logic [3:0]      wr_ptr_o,
  output logic [3:0]      rd_ptr_o,
  output logic            full_o,
  output logic            empty_o,
  output logic            overrun_o,
  output logic            underrun_o
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][9:0] mem;
    logic [3:0]            wr;
    logic [3:0]            rd;
    logic [3:0]            count;
    logic [9:0]            head;
  } queue_state_t;

  localparam logic [3:0] LAST = 4'(DEPTH - 1);
  localparam logic [3:0] FULL = 4'(DEPTH);

  queue_state_t q_q;
  queue_state_t q_d;
  logic         do_push;
  logic         do_pop;

  assign do_push    = push_i && (q_q.count != FULL);
  assign do_pop     = pop_i && (q_q.count != 4'h0);
  assign overrun_o  = push_i && (q_q.count == FULL);
  assign underrun_o = pop_i && (q_q.count == 4'h0);

  // Pointer wrap, storage and head prefetch.
  always_comb begin
    q_d = q_q;
    if (do_push) begin
      q_d.mem[q_q.wr] = push_data_i;
      q_d.wr          = (q_q.wr == LAST) ? 4'h0 : q_q.wr + 4'h1;
    end
    if (do_pop) begin
      q_d.rd = (q_q.rd == LAST) ? 4'h0 : q_q.rd + 4'h1;
    end
    q_d.count = q_q.count + {3'h0, do_push} - {3'h0, do_pop};
    q_d.head  = q_d.mem[q_d.rd];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  assign head_data_o = q_q.head;
  assign wr_ptr_o    = q_q.wr;
  assign rd_ptr_o    = q_q.rd;
  assign full_o      = (q_q.count == FULL);
  assign empty_o     = (q_q.count == 4'h0);

endmodule

// File: verilog/sample_averager.sv
/*
  Shared averager: accumulates 2^log2n conversions and emits their mean.
  With log2n zero every conversion passes straight through one cycle later.
  Assumes the caller clears it when a sequence starts or is abandoned.
*/
`timescale 1ns/1ps
`include "adc_seq_map.svh"
module sample_averager (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clear_i,
  input  wire logic       in_valid_i,
  input  wire logic [9:0] in_data_i,
  input  wire logic [2:0] log2n_i,
  output logic            out_valid_o,
  output logic [9:0]      out_data_o
);

  typedef struct packed {
    logic [15:0] acc;
    logic [6:0]  cnt;
    logic        valid;
    logic [9:0]  data;
  } avg_state_t;

  avg_state_t a_q;
  avg_state_t a_d;
  logic [2:0]  shift;
  logic [15:0] sum;
  logic [15:0] mean;

  // Larger settings are held at the deepest supported average.
  assign shift = (log2n_i > `MAX_AVG_LOG2) ? `MAX_AVG_LOG2 : log2n_i;
  assign sum   = a_q.acc + {6'h0, in_data_i};
  assign mean  = sum >> shift;

  // Accumulate and release one mean per full group.
  always_comb begin
    a_d       = a_q;
    a_d.valid = 1'b0;
    if (clear_i) begin
      a_d.acc = 16'h0000;
      a_d.cnt = 7'h00;
    end else if (in_valid_i) begin
      if ((a_q.cnt + 7'h01) == (7'h01 << shift)) begin
        a_d.acc   = 16'h0000;
        a_d.cnt   = 7'h00;
        a_d.valid = 1'b1;
        a_d.data  = mean[9:0];
      end else begin
        a_d.acc = sum;
        a_d.cnt = a_q.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      a_q <= '0;
    end else begin
      a_q <= a_d;
    end
  end

  assign out_valid_o = a_q.valid;
  assign out_data_o  = a_q.data;

endmodule

// File: tb/adc_seq_chk.sv
/* Port checker of the sequencer control block.
   Assumes a bind onto the top module. */
`timescale 1ns/1ps
module adc_seq_chk (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire adc_seq_pkg::apb_req_t  apb_req_i,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  input wire adc_seq_pkg::conv_req_t conv_req_o,
  input wire adc_seq_pkg::conv_rsp_t conv_rsp_i,
  input wire logic                   adc_clk_o,
  input wire logic [3:0]             irq_o
);
  // A completed bus write.
  logic acc;
  assign acc = pready_o && apb_req_i.pwrite;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus, converter and interrupt relations.
  AST_RDY_ONE: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  AST_RDY_WAIT: assert property (apb_req_i.psel && !apb_req_i.penable
    |=> !pready_o ##1 pready_o)
    else $error("wait state wrong");
  AST_ERR_RDY: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  AST_GATE: assert property (acc && apb_req_i.paddr == 12'h008 |=>
    (irq_o & ~$past(apb_req_i.pwdata[3:0])) == 4'h0)
    else $error("unmasked interrupt");
  AST_CLEAR: assert property (acc && apb_req_i.paddr == 12'h00C &&
    !conv_rsp_i.done && !$past(conv_rsp_i.done) &&
    !$past(conv_rsp_i.done, 2) |=>
    (irq_o & $past(apb_req_i.pwdata[3:0])) == 4'h0)
    else $error("interrupt not cleared");
  AST_DIV: assert property ($rose(adc_clk_o) |->
    adc_clk_o[*6] ##1 !adc_clk_o[*6] ##1 adc_clk_o)
    else $error("converter clock rate");
  AST_GAP: assert property (conv_req_o.start |=>
    !conv_req_o.start[*8])
    else $error("starts too close");
  AST_HOLD: assert property (conv_req_o.start |=>
    $stable({conv_req_o.input_sel, conv_req_o.step_ctl})[*4])
    else $error("step nibbles moved");
endmodule

// File: tb/conv_core_model.sv
/* Converter core model: answers each start after lat_i plus two cycles.
   Assumes start pulses on clk_i; data toggles when not valid. */
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic                   clk_i,
  input  wire adc_seq_pkg::conv_req_t req_i,
  input  wire logic [3:0]             lat_i,
  output adc_seq_pkg::conv_rsp_t      rsp_o
);
  int         cnt = 0;
  logic [3:0] sel = 4'h0;
  initial rsp_o = '0;
  // Result carries the converted input code in its upper bits.
  always @(posedge clk_i) begin
    rsp_o.done <= (cnt == 1);
    rsp_o.data <= (cnt == 1) ? {sel, 6'h2B} : ~rsp_o.data;
    cnt <= req_i.start ? int'(lat_i) + 2 : (cnt > 0 ? cnt - 1 : 0);
    if (req_i.start) sel <= req_i.input_sel;
  end
endmodule

// File: tb/tb_top.sv
/* Self-checking bench of the sequencer control block.
   Assumes the converter model and the checker. */
`timescale 1ns/1ps
module tb_top;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  adc_seq_pkg::apb_req_t  req = '0;
  adc_seq_pkg::conv_req_t creq;
  adc_seq_pkg::conv_rsp_t crsp;
  logic [31:0]            prdata;
  logic                   rdy, err, aclk;
  logic [3:0]             irq, lat = 4'h0, trig = 4'h0;
  logic [32:0]            expq[$];
  logic [31:0]            rnd = 32'hD2EB912F;
  int                     errors = 0, compares = 0, starts = 0;
  adc_sample_sequencer_control dut (.clk_i(clk_i), .rst_i(rst_i),
    .apb_req_i(req), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(err),
    .conv_req_o(creq), .conv_rsp_i(crsp), .periph_trig_i(trig),
    .adc_clk_o(aclk), .irq_o(irq));
  conv_core_model core (.clk_i(clk_i), .req_i(creq), .lat_i(lat),
    .rsp_o(crsp));
  initial forever #2.5 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer held until ready, then one idle cycle.
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      give_verdict();
    end
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Read answers are checked against the oldest expectation.
  always @(posedge clk_i) begin
    if (rdy === 1'b1 && req.pwrite === 1'b0) chk({err, prdata},
      expq.pop_front());
    if (creq.start === 1'b1) starts++;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h020, 33'h3210);
    rd(12'h0A4, 33'h2);
    rd(12'h04C, 33'h100);
    rd(12'h030, 33'h0);
    rd(12'hFFC, {1'b1, 32'h0});
    $display("reset test done");
    rnd = xs(rnd);
    lat <= rnd[7:4];
    bus(1'b1, 12'h064, 32'h604);
    bus(1'b1, 12'h060, {16'h0, rnd[15:0]});
    bus(1'b1, 12'h008, 32'h2);
    bus(1'b1, 12'h000, 32'h2);
    bus(1'b1, 12'h028, 32'h2);
    for (int i = 0; i < 400 && starts < 3; i++) @(posedge clk_i);
    repeat (40) @(posedge clk_i);
    chk(33'(starts), 33'h3);
    chk({29'h0, irq}, 33'h2);
    rd(12'h004, 33'h2);
    for (int i = 0; i < 3; i++) rd(12'h068, {23'h0, rnd[4*i+:4], 6'h2B});
    rd(12'h06C, 33'h133);
    bus(1'b1, 12'h00C, 32'h2);
    chk({29'h0, irq}, 33'h0);
    rd(12'h004, 33'h0);
    rd(12'h0A8, 33'h0);
    rd(12'h018, 33'h8);
    $display("sequence test done");
    bus(1'b1, 12'h030, 32'h1);
    bus(1'b1, 12'h014, 32'h1000);
    bus(1'b1, 12'h000, 32'h8);
    trig <= 4'h1;
    repeat (100) @(posedge clk_i);
    rd(12'h0A8, 33'h2B);
    bus(1'b1, 12'h100, 32'h1);
    trig <= 4'h0;
    repeat (5) @(posedge clk_i);
    trig <= 4'h1;
    repeat (60) @(posedge clk_i);
    rd(12'h0A8, 33'h300);
    chk(33'(starts), 33'h5);
    $display("trigger test done");
    give_verdict();
  end
endmodule
bind adc_sample_sequencer_control adc_seq_chk chk (.*);
